/* File: src/cbsc_defines.svh */
// How it works
// - as target, assert device select to claim cycles hitting our window
// - as initiator, abort the cycle if no device select before timeout
// - initiator drives frame low at start, low while more data follows
// - frame high marks the final data phase for both sides
// - a data phase completes only when both ready strobes are low
// - grant goes to the card only after our own transaction is complete
// - target drives parity error low two clocks after bad data, not special
// - target stop ends the transaction; initiator stops on it
// - card system error is forwarded to the host side system error
// - binary audio level from the card goes to the speaker output
// - status change input is reported and raises a wake-up event
// - bus lock gives an initiator exclusive access; host starts wait out a card lock, the target ignores lock
// - detect and voltage-sense lines give insertion state and card voltage
// - even parity over address/data and command lines, driven one clock later
// - command in address phase, byte enables in data phases, bit 0 lowest
`ifndef CBSC_DEFINES_SVH
`define CBSC_DEFINES_SVH

// link clocks without device select before the initiator gives up
`define CBSC_DEVSEL_TIMEOUT 5
`define CBSC_TO_W           4
`define CBSC_CMD_SPECIAL    4'h1
`define CBSC_CMD_WR_BIT     0
`define CBSC_SYNC_W         53
// default target window
`define CBSC_TGT_BASE       32'h0000_0000
`define CBSC_TGT_MASK       32'hFFFF_F000

`endif

/* File: src/cbsc_pkg.sv */
package cbsc_pkg;
	typedef enum logic [1:0] {I_IDLE, I_ADDR, I_DATA, I_TURN} cbsc_ist_t;
	typedef enum logic [1:0] {T_IDLE, T_WAIT, T_DATA, T_TURN} cbsc_tst_t;
	typedef enum logic [1:0] {CD_ABSENT, CD_PARTIAL, CD_SEATED} cbsc_cd_t;
endpackage : cbsc_pkg

/* File: src/cbsc_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser, first stage read only by the second
module cbsc_sync #(
	parameter int          P_W   = 1,
	parameter logic [P_W-1:0] P_RST = '1
) (
	input  wire logic           i_clk,
	input  wire logic           i_rstn,
	input  wire logic           i_ce,
	input  wire logic [P_W-1:0] i_d,
	output logic      [P_W-1:0] o_q
);
	logic [P_W-1:0] meta_r;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_r <= P_RST;
			o_q    <= P_RST;
		end else if (i_ce) begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end
endmodule : cbsc_sync

/* File: src/cbsc_top.sv */
`timescale 1ns/1ps
`include "cbsc_defines.svh"
module cbsc_top #(
	parameter logic [31:0] P_BASE    = `CBSC_TGT_BASE,
	parameter logic [31:0] P_MASK    = `CBSC_TGT_MASK,
	parameter int          P_TIMEOUT = `CBSC_DEVSEL_TIMEOUT
) (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_ce,
	input  wire logic        i_req,
	input  wire logic [3:0]  i_cmd,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_be_n,
	input  wire logic        i_lock,
	output logic             o_done,
	output logic             o_abort,
	output logic             o_disc,
	output logic      [31:0] o_rdata,
	input  wire logic [31:0] i_tgt_rdata,
	output logic             o_tgt_wr,
	output logic      [31:0] o_tgt_addr,
	output logic      [31:0] o_tgt_wdata,
	output logic      [3:0]  o_tgt_be,
	output logic             o_tgt_perr,
	input  wire logic        i_audio_en,
	output logic             o_speaker_out,
	output logic             o_irq,
	output logic             o_wake,
	output logic             o_serr_n,
	output cbsc_pkg::cbsc_cd_t o_cd_state,
	output logic      [1:0]  o_vsense,
	input  wire logic        i_cclk,
	input  wire logic        i_cframe_n,
	output logic             o_cframe_n,
	output logic             o_cframe_oe,
	input  wire logic        i_cirdy_n,
	output logic             o_cirdy_n,
	output logic             o_cirdy_oe,
	input  wire logic        i_ctrdy_n,
	output logic             o_ctrdy_n,
	output logic             o_ctrdy_oe,
	input  wire logic        i_cdevsel_n,
	output logic             o_cdevsel_n,
	output logic             o_cdevsel_oe,
	input  wire logic        i_cstop_n,
	output logic             o_cstop_n,
	output logic             o_cstop_oe,
	output logic             o_cperr_n,
	output logic             o_cperr_oe,
	input  wire logic        i_cpar,
	output logic             o_cpar,
	output logic             o_cpar_oe,
	input  wire logic        i_cblock_n,
	output logic             o_cblock_n,
	output logic             o_cblock_oe,
	input  wire logic [31:0] i_cad,
	output logic      [31:0] o_cad,
	output logic             o_cad_oe,
	input  wire logic [3:0]  i_ccbe_n,
	output logic      [3:0]  o_ccbe_n,
	output logic             o_ccbe_oe,
	output logic             o_cgnt_n,
	input  wire logic        i_creq_n,
	input  wire logic        i_cserr_n,
	input  wire logic        i_cint_n,
	input  wire logic        i_caudio,
	input  wire logic        i_cstschg,
	input  wire logic        i_ccd1_n,
	input  wire logic        i_ccd2_n,
	input  wire logic        i_cvs1,
	input  wire logic        i_cvs2
);
	logic s_cclk, s_frame_n, s_irdy_n, s_trdy_n, s_devsel_n, s_stop_n;
	logic s_par, s_lock_n, s_creq_n, s_serr_n, s_cint_n, s_audio;
	logic s_stschg, s_cd1_n, s_cd2_n, s_vs1, s_vs2;
	logic [3:0]  s_cbe_n;
	logic [31:0] s_ad;
	logic [`CBSC_SYNC_W-1:0] sync_q;
	logic [`CBSC_SYNC_W-1:0] samp_r;
	logic cclk_d_r, frame_d_r, stschg_d_r, tchk_r, tpar_r, ev, start;
	logic [`CBSC_TO_W-1:0] cnt_r;
	logic [3:0] icmd_r, tcmd_r;
	cbsc_pkg::cbsc_ist_t ist_r;
	cbsc_pkg::cbsc_tst_t tst_r;

	// synchroniser resets high except status change, which idles low;
	// keeps the wake detector from seeing a false edge after reset
	localparam logic [`CBSC_SYNC_W-1:0] SYNC_RST =
		{12'hFFF, 1'b0, 40'hFF_FFFF_FFFF};

	// every pin crosses two flops before use
	cbsc_sync #(
		.P_W   (`CBSC_SYNC_W),
		.P_RST (SYNC_RST)
	) i_cbsc_sync (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_ce   (i_ce),
		.i_d    ({i_cclk, i_cframe_n, i_cirdy_n, i_ctrdy_n, i_cdevsel_n,
		          i_cstop_n, i_cpar, i_cblock_n, i_creq_n, i_cserr_n,
		          i_cint_n, i_caudio, i_cstschg, i_ccd1_n, i_ccd2_n,
		          i_cvs1, i_cvs2, i_ccbe_n, i_cad}),
		.o_q    (sync_q)
	);
	// link clock straight from the synchroniser, bus pins one i_clk older:
	// at a detected rise they still show the level from before the edge
	assign s_cclk = sync_q[`CBSC_SYNC_W-1];
	assign {s_frame_n, s_irdy_n, s_trdy_n, s_devsel_n, s_stop_n,
	        s_par, s_lock_n, s_creq_n, s_serr_n, s_cint_n, s_audio,
	        s_stschg, s_cd1_n, s_cd2_n, s_vs1, s_vs2, s_cbe_n, s_ad} =
	       samp_r[`CBSC_SYNC_W-2:0];

	// pre-edge sample, so both ready strobes are judged at the same edge
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			samp_r <= SYNC_RST;
		else if (i_ce)
			samp_r <= sync_q;
	end

	// link rising edge; all bus logic steps only here
	assign ev = i_ce & s_cclk & ~cclk_d_r;
	// start only on an idle bus, not granted away, not locked by the card
	assign start = ev && ist_r == cbsc_pkg::I_IDLE && i_req && o_cgnt_n &&
	               s_frame_n && s_irdy_n && (s_lock_n || o_cblock_oe);

	// edge history
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cclk_d_r  <= 1'b1;
			frame_d_r <= 1'b1;
		end else if (i_ce) begin
			cclk_d_r <= s_cclk;
			if (ev)
				frame_d_r <= s_frame_n;
		end
	end

	// initiator sequence: single data phase per request
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ist_r       <= cbsc_pkg::I_IDLE;
			o_cframe_n  <= 1'b1;
			o_cframe_oe <= 1'b0;
			o_cirdy_n   <= 1'b1;
			o_cirdy_oe  <= 1'b0;
			o_cblock_n  <= 1'b1;
			o_cblock_oe <= 1'b0;
			cnt_r       <= '0;
			icmd_r      <= '0;
			o_done      <= 1'b0;
			o_abort     <= 1'b0;
			o_disc      <= 1'b0;
			o_rdata     <= '0;
		end else if (i_ce) begin
			o_done  <= 1'b0;
			o_abort <= 1'b0;
			o_disc  <= 1'b0;
			if (ev) begin
				case (ist_r)
				cbsc_pkg::I_IDLE: begin
					if (!i_lock) begin // lock spans transactions until dropped
						o_cblock_n  <= 1'b1;
						o_cblock_oe <= 1'b0;
					end
					if (start) begin
						o_cframe_n  <= 1'b0;
						o_cframe_oe <= 1'b1;
						o_cirdy_oe  <= 1'b1;
						cnt_r       <= '0;
						icmd_r      <= i_cmd;
						ist_r       <= cbsc_pkg::I_ADDR;
					end
				end
				cbsc_pkg::I_ADDR: begin
					o_cframe_n <= 1'b1; // single phase, so it is the last
					o_cirdy_n  <= 1'b0;
					if (i_lock) begin
						o_cblock_n  <= 1'b0;
						o_cblock_oe <= 1'b1;
					end
					ist_r <= cbsc_pkg::I_DATA;
				end
				cbsc_pkg::I_DATA: begin
					if (!s_devsel_n && !s_trdy_n) begin
						o_done    <= 1'b1;
						o_disc    <= ~s_stop_n;
						o_rdata   <= s_ad;
						o_cirdy_n <= 1'b1;
						ist_r     <= cbsc_pkg::I_TURN;
					end else if (!s_devsel_n && !s_stop_n) begin
						o_disc    <= 1'b1;
						o_cirdy_n <= 1'b1;
						ist_r     <= cbsc_pkg::I_TURN;
					end else if (s_devsel_n &&
					             cnt_r == `CBSC_TO_W'(P_TIMEOUT)) begin
						o_abort   <= 1'b1;
						o_cirdy_n <= 1'b1;
						ist_r     <= cbsc_pkg::I_TURN;
					end else if (s_devsel_n) begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				cbsc_pkg::I_TURN: begin
					// strobes were parked high one clock before release
					o_cframe_oe <= 1'b0;
					o_cirdy_oe  <= 1'b0;
					ist_r       <= cbsc_pkg::I_IDLE;
				end
				default: ist_r <= cbsc_pkg::I_IDLE;
				endcase
			end
		end
	end

	// target sequence: claim, wait one clock for turnaround, one data phase
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tst_r        <= cbsc_pkg::T_IDLE;
			o_cdevsel_n  <= 1'b1;
			o_cdevsel_oe <= 1'b0;
			o_ctrdy_n    <= 1'b1;
			o_ctrdy_oe   <= 1'b0;
			o_cstop_n    <= 1'b1;
			o_cstop_oe   <= 1'b0;
			tcmd_r       <= '0;
			tchk_r       <= 1'b0;
			tpar_r       <= 1'b0;
			o_tgt_wr     <= 1'b0;
			o_tgt_addr   <= '0;
			o_tgt_wdata  <= '0;
			o_tgt_be     <= '0;
		end else if (i_ce) begin
			o_tgt_wr <= 1'b0;
			if (ev) begin
				tchk_r <= 1'b0;
				case (tst_r)
				cbsc_pkg::T_IDLE: begin
					if (!s_frame_n && frame_d_r && !o_cframe_oe &&
					    (s_ad & P_MASK) == P_BASE) begin
						tcmd_r       <= s_cbe_n; // command lanes
						o_tgt_addr   <= s_ad;
						o_cdevsel_n  <= 1'b0;
						o_cdevsel_oe <= 1'b1;
						o_ctrdy_oe   <= 1'b1;
						o_cstop_oe   <= 1'b1;
						tst_r        <= cbsc_pkg::T_WAIT;
					end
				end
				cbsc_pkg::T_WAIT: begin
					o_ctrdy_n <= 1'b0;
					// no bursts: disconnect with data if frame still low
					o_cstop_n <= s_frame_n;
					tst_r     <= cbsc_pkg::T_DATA;
				end
				cbsc_pkg::T_DATA: begin
					if (!s_irdy_n) begin // both ready low
						o_tgt_wr    <= tcmd_r[`CBSC_CMD_WR_BIT];
						o_tgt_wdata <= s_ad;
						o_tgt_be    <= ~s_cbe_n; // bit 0 is lane 0
						tpar_r      <= ^{s_ad, s_cbe_n};
						tchk_r      <= 1'b1;
						o_cdevsel_n <= 1'b1;
						o_ctrdy_n   <= 1'b1;
						o_cstop_n   <= 1'b1;
						tst_r       <= cbsc_pkg::T_TURN;
					end
				end
				cbsc_pkg::T_TURN: begin
					o_cdevsel_oe <= 1'b0;
					o_ctrdy_oe   <= 1'b0;
					o_cstop_oe   <= 1'b0;
					tst_r        <= cbsc_pkg::T_IDLE;
				end
				default: tst_r <= cbsc_pkg::T_IDLE;
				endcase
			end
		end
	end

	// address/data drivers for both roles, command drivers for the initiator only
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cad     <= '0;
			o_cad_oe  <= 1'b0;
			o_ccbe_n  <= '1;
			o_ccbe_oe <= 1'b0;
		end else if (ev) begin
			if (start) begin
				o_cad     <= i_addr;
				o_cad_oe  <= 1'b1;
				o_ccbe_n  <= i_cmd;
				o_ccbe_oe <= 1'b1;
			end else if (ist_r == cbsc_pkg::I_ADDR) begin
				o_ccbe_n <= i_be_n;
				o_cad    <= i_wdata;
				o_cad_oe <= icmd_r[`CBSC_CMD_WR_BIT];
			end else if (ist_r == cbsc_pkg::I_TURN) begin
				o_cad_oe  <= 1'b0;
				o_ccbe_oe <= 1'b0;
			end else if (tst_r == cbsc_pkg::T_WAIT &&
			             !tcmd_r[`CBSC_CMD_WR_BIT]) begin
				o_cad    <= i_tgt_rdata;
				o_cad_oe <= 1'b1;
			end else if (tst_r == cbsc_pkg::T_DATA && !s_irdy_n) begin
				o_cad_oe <= 1'b0;
			end
		end
	end

	// even parity, one link clock behind what it
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cpar    <= 1'b0;
			o_cpar_oe <= 1'b0;
		end else if (ev) begin
			o_cpar    <= ^{o_cad, (o_ccbe_oe ? o_ccbe_n : s_cbe_n)};
			o_cpar_oe <= o_cad_oe;
		end
	end

	// parity error: low at the second clock after the data
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cperr_n  <= 1'b1;
			o_cperr_oe <= 1'b0;
			o_tgt_perr <= 1'b0;
		end else if (i_ce) begin
			o_tgt_perr <= 1'b0;
			if (ev) begin
				if (tchk_r && s_par != tpar_r &&
				    tcmd_r != `CBSC_CMD_SPECIAL) begin
					o_cperr_n  <= 1'b0;
					o_cperr_oe <= 1'b1;
					o_tgt_perr <= 1'b1;
				end else if (!o_cperr_n) begin
					o_cperr_n <= 1'b1; // park high before release
				end else begin
					o_cperr_oe <= 1'b0;
				end
			end
		end
	end

	// arbiter: grant only between our transactions
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cgnt_n <= 1'b1;
		end else if (ev) begin
			if (s_creq_n)
				o_cgnt_n <= 1'b1;
			else if (ist_r == cbsc_pkg::I_IDLE && !start &&
			         s_frame_n && s_irdy_n)
				o_cgnt_n <= 1'b0;
		end
	end

	// sideband: audio, interrupt, errors, status change, detect
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_speaker_out <= 1'b0;
			o_irq         <= 1'b0;
			o_serr_n      <= 1'b1;
			o_wake        <= 1'b0;
			stschg_d_r    <= 1'b0;
			o_cd_state    <= cbsc_pkg::CD_ABSENT;
			o_vsense      <= '0;
		end else if (i_ce) begin
			o_speaker_out <= i_audio_en & s_audio;
			o_irq         <= ~s_cint_n;
			// level follows the pin, so a slow pull-up release is harmless
			o_serr_n      <= s_serr_n;
			stschg_d_r    <= s_stschg;
			o_wake        <= s_stschg ^ stschg_d_r;
			o_vsense      <= {s_vs2, s_vs1};
			if (!s_cd1_n && !s_cd2_n)
				o_cd_state <= cbsc_pkg::CD_SEATED;
			else if (!s_cd1_n || !s_cd2_n)
				o_cd_state <= cbsc_pkg::CD_PARTIAL;
			else
				o_cd_state <= cbsc_pkg::CD_ABSENT;
		end
	end

	property p_gnt_idle;
		@(posedge i_clk) disable iff (!i_rstn)
		!o_cgnt_n |-> ist_r == cbsc_pkg::I_IDLE && !o_cframe_oe;
	endproperty
	a_gnt_idle: assert property (p_gnt_idle)
		else $error("grant while own transaction active");

	property p_gnt_drop;
		@(posedge i_clk) disable iff (!i_rstn)
		ev && s_creq_n |=> o_cgnt_n;
	endproperty
	a_gnt_drop: assert property (p_gnt_drop)
		else $error("grant kept after request removed");

	property p_timeout;
		@(posedge i_clk) disable iff (!i_rstn)
		o_abort |-> $past(s_devsel_n) &&
		            $past(cnt_r) == `CBSC_TO_W'(P_TIMEOUT);
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("abort without device select timeout");

	property p_cnt_max;
		@(posedge i_clk) disable iff (!i_rstn)
		cnt_r <= `CBSC_TO_W'(P_TIMEOUT);
	endproperty
	a_cnt_max: assert property (p_cnt_max)
		else $error("device select counter past its limit");

	property p_frame_last;
		@(posedge i_clk) disable iff (!i_rstn)
		o_cframe_oe && !o_cframe_n |-> ist_r == cbsc_pkg::I_ADDR && o_cad_oe;
	endproperty
	a_frame_last: assert property (p_frame_last)
		else $error("frame low outside address phase");

	property p_done_rdy;
		@(posedge i_clk) disable iff (!i_rstn)
		o_done |-> !$past(o_cirdy_n) && !$past(s_trdy_n) &&
		           !$past(s_devsel_n);
	endproperty
	a_done_rdy: assert property (p_done_rdy)
		else $error("data phase done without both ready");

	property p_par;
		@(posedge i_clk) disable iff (!i_rstn)
		ev |=> o_cpar_oe == $past(o_cad_oe);
	endproperty
	a_par: assert property (p_par)
		else $error("parity enable not one clock behind data");

	property p_perr;
		@(posedge i_clk) disable iff (!i_rstn)
		$fell(o_cperr_n) |-> tcmd_r != `CBSC_CMD_SPECIAL &&
		                     tst_r == cbsc_pkg::T_IDLE;
	endproperty
	a_perr: assert property (p_perr)
		else $error("parity error at wrong time");

	property p_devsel;
		@(posedge i_clk) disable iff (!i_rstn)
		!o_cdevsel_n |-> o_cdevsel_oe && tst_r != cbsc_pkg::T_IDLE;
	endproperty
	a_devsel: assert property (p_devsel)
		else $error("device select outside a claim");

	property p_stop;
		@(posedge i_clk) disable iff (!i_rstn)
		!o_cstop_n |-> !o_cdevsel_n && !o_ctrdy_n;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop without select and ready");

	property p_audio;
		@(posedge i_clk) disable iff (!i_rstn)
		i_ce |=> o_speaker_out == ($past(i_audio_en) && $past(s_audio));
	endproperty
	a_audio: assert property (p_audio)
		else $error("speaker does not follow card audio");

	c_done:  cover property (@(posedge i_clk) disable iff (!i_rstn) o_done);
	c_abort: cover property (@(posedge i_clk) disable iff (!i_rstn) o_abort);
	c_twr:   cover property (@(posedge i_clk) disable iff (!i_rstn) o_tgt_wr);
	c_gnt:   cover property (@(posedge i_clk) disable iff (!i_rstn)
	                         $fell(o_cgnt_n));
endmodule : cbsc_top

/* File: tb/cbsc_card_model.sv */
`timescale 1ns/1ps
// card in the socket: target for host cycles, initiator on request
module cbsc_card_model (
	input  wire logic        i_cclk,
	input  wire logic [1:0]  i_wait,
	input  wire logic        i_stop,
	input  wire logic [31:0] i_rdata,
	input  wire logic [9:0]  i_oe,
	input  wire logic [7:0]  i_v,
	input  wire logic [31:0] i_cad,
	input  wire logic [3:0]  i_cbe_n,
	input  wire logic        i_gnt_n,
	output logic             o_req_n,
	output logic      [7:0]  o_w,
	output logic      [31:0] o_cad,
	output logic      [3:0]  o_cbe_n
);
	logic [7:0]  m_oe = '0, m_v = '1;
	logic [31:0] m_cad = '0, got_addr, got_data;
	logic [3:0]  m_cbe = '0, got_cmd, got_be;
	logic        m_cad_oe = 0, m_cbe_oe = 0, pat = 0, rd, t0, claim;
	logic        claim_d = 0, got_frame, got_lock, par_seen, got_stop = 0;
	logic [1:0]  st = '0, wt;
	int          cyc = 0, done_cyc = 0, perr_cyc = 0;

	initial o_req_n = 1'b1;
	// released strobes float high; data lines show a toggling pattern
	assign o_w = (i_oe[7:0] & i_v) | (~i_oe[7:0] & m_oe & m_v)
		| (~i_oe[7:0] & ~m_oe & {1'b1, pat, 6'h3F});
	assign o_cad = i_oe[8] ? i_cad : m_cad_oe ? m_cad
		: {32{pat}} ^ 32'h5A5A_A5A5;
	assign o_cbe_n = i_oe[9] ? i_cbe_n : m_cbe_oe ? m_cbe : {4{pat}} ^ 4'h5;
	assign claim = st == 2'd0 && o_w[0] === 1'b0 && !m_oe[0]
		&& o_cad[31:28] == 4'h8;

	// target side, all changes just after a link rise
	always @(posedge i_cclk) begin
		cyc <= cyc + 1;
		pat <= ~pat;
		claim_d <= claim;
		if (claim_d)
			par_seen <= o_w[6];
		if (o_w[5] === 1'b0)
			perr_cyc <= cyc;
		case (st)
		2'd0: if (claim) begin
			rd = !o_cbe_n[0];
			t0 = !rd && i_wait == 2'd0;
			got_addr <= o_cad;
			got_cmd <= o_cbe_n;
			wt <= t0 ? 2'd0 : (i_wait == 2'd0 ? 2'd1 : i_wait);
			m_oe[4:2] <= 3'b111;
			m_v[4:2] <= {!(t0 && i_stop), 1'b0, !t0};
			st <= 2'd1;
		end
		2'd1: if (!m_v[2] && o_w[1] === 1'b0) begin
			got_data <= o_cad;
			got_be <= o_cbe_n;
			got_frame <= o_w[0];
			got_lock <= o_w[7];
			m_v[4:2] <= 3'b111;
			m_cad_oe <= 1'b0;
			m_oe[6] <= rd;
			m_v[6] <= ^{m_cad, o_cbe_n};
			st <= 2'd2;
		end else if (wt <= 2'd1) begin
			m_v[2] <= 1'b0;
			m_v[4] <= !i_stop;
			m_cad <= i_rdata;
			m_cad_oe <= rd;
		end else
			wt <= wt - 2'd1;
		default: begin
			m_oe[6:2] <= '0;
			st <= 2'd0;
		end
		endcase
	end

	// one card-initiated data phase; ok low on no grant or no claim
	task automatic card_xfer(input logic [3:0] cmd, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] be_n, input logic bad,
		input logic brst, output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge i_cclk) o_req_n <= 1'b0;
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge i_cclk);
			ok = i_gnt_n === 1'b0;
		end
		if (ok) begin
			m_oe[1:0] <= 2'b11;
			m_v[1:0] <= 2'b10;
			m_cad <= a;
			m_cbe <= cmd;
			m_cad_oe <= 1'b1;
			m_cbe_oe <= 1'b1;
			@(posedge i_cclk);
			o_req_n <= 1'b1;
			m_v[1:0] <= {1'b0, !brst}; // burst keeps frame low
			m_cbe <= be_n;
			m_cad <= d;
			m_cad_oe <= cmd[0];
			m_oe[6] <= 1'b1;
			m_v[6] <= ^{a, cmd};
			ok = 1'b0;
			for (n = 0; n < 20 && !ok; n++) begin
				@(posedge i_cclk);
				ok = o_w[3:2] === 2'b00;
				m_oe[6] <= cmd[0];
				m_v[6] <= ^{d, be_n} ^ bad;
			end
			q = o_cad;
			got_stop = o_w[4] === 1'b0;
			done_cyc = cyc;
			m_v[1] <= 1'b1;
			m_oe[0] <= 1'b0;
			m_cad_oe <= 1'b0;
			m_cbe_oe <= 1'b0;
		end
		@(posedge i_cclk);
		o_req_n <= 1'b1;
		m_oe[1] <= 1'b0;
		m_oe[6] <= 1'b0;
	endtask : card_xfer
endmodule : cbsc_card_model

/* File: tb/cbsc_top_tb.sv */
`timescale 1ns/1ps
// host cycles, card cycles and sideband pins against the socket block
module cbsc_top_tb;
	logic        i_clk = 0, i_rstn = 0, i_cclk = 0, i_req = 0, i_lock = 0;
	logic        i_audio_en = 0, i_caudio = 0, i_cstschg = 0, i_cint_n = 1;
	logic        i_cserr_n = 1, i_ccd1_n = 1, i_ccd2_n = 1, i_cvs1 = 0;
	logic        i_cvs2 = 0, c_stop = 0;
	logic [1:0]  c_wait = '0;
	logic [3:0]  i_cmd = '0, i_be_n = '0;
	logic [31:0] i_addr = '0, i_wdata = '0, i_tgt_rdata = '0, c_rdata = '0;
	logic        o_done, o_abort, o_disc, o_tgt_wr, o_tgt_perr, o_irq;
	logic        o_speaker_out, o_wake, o_serr_n, gnt_n, req_n;
	logic [31:0] o_rdata, o_tgt_addr, o_tgt_wdata, d_cad, w_cad;
	logic [3:0]  o_tgt_be, d_cbe_n, w_cbe_n;
	logic [1:0]  o_vsense;
	logic [7:0]  w;
	wire  [9:0]  d_oe;
	wire  [7:0]  d_v;
	cbsc_pkg::cbsc_cd_t o_cd_state;
	int          miscompares = 0, checks = 0, n_wr = 0, n_perr = 0;
	int          n_wake = 0;

	always #5 i_clk = ~i_clk;
	// link clock unrelated in phase to the system clock
	always #62.5 i_cclk = ~i_cclk;

	cbsc_top #(.P_TIMEOUT(2)) i_cbsc_top (
		.i_clk, .i_rstn, .i_ce(1'b1), .i_req, .i_cmd, .i_addr, .i_wdata,
		.i_be_n, .i_lock, .o_done, .o_abort, .o_disc, .o_rdata, .i_tgt_rdata,
		.o_tgt_wr, .o_tgt_addr, .o_tgt_wdata, .o_tgt_be, .o_tgt_perr,
		.i_audio_en, .o_speaker_out, .o_irq, .o_wake, .o_serr_n, .o_cd_state,
		.o_vsense, .i_cclk, .i_cframe_n(w[0]), .o_cframe_n(d_v[0]),
		.o_cframe_oe(d_oe[0]), .i_cirdy_n(w[1]), .o_cirdy_n(d_v[1]),
		.o_cirdy_oe(d_oe[1]), .i_ctrdy_n(w[2]), .o_ctrdy_n(d_v[2]),
		.o_ctrdy_oe(d_oe[2]), .i_cdevsel_n(w[3]), .o_cdevsel_n(d_v[3]),
		.o_cdevsel_oe(d_oe[3]), .i_cstop_n(w[4]), .o_cstop_n(d_v[4]),
		.o_cstop_oe(d_oe[4]), .o_cperr_n(d_v[5]), .o_cperr_oe(d_oe[5]),
		.i_cpar(w[6]), .o_cpar(d_v[6]), .o_cpar_oe(d_oe[6]),
		.i_cblock_n(w[7]), .o_cblock_n(d_v[7]), .o_cblock_oe(d_oe[7]),
		.i_cad(w_cad), .o_cad(d_cad), .o_cad_oe(d_oe[8]), .i_ccbe_n(w_cbe_n),
		.o_ccbe_n(d_cbe_n), .o_ccbe_oe(d_oe[9]), .o_cgnt_n(gnt_n),
		.i_creq_n(req_n), .i_cserr_n, .i_cint_n, .i_caudio, .i_cstschg,
		.i_ccd1_n, .i_ccd2_n, .i_cvs1, .i_cvs2);

	cbsc_card_model i_cbsc_card_model (
		.i_cclk, .i_wait(c_wait), .i_stop(c_stop), .i_rdata(c_rdata),
		.i_oe(d_oe), .i_v(d_v), .i_cad(d_cad), .i_cbe_n(d_cbe_n),
		.i_gnt_n(gnt_n), .o_req_n(req_n), .o_w(w), .o_cad(w_cad),
		.o_cbe_n(w_cbe_n));

	// pulses stand one cycle, so tally them as they pass
	always @(posedge i_clk) begin
		n_wr <= n_wr + (o_tgt_wr === 1'b1);
		n_perr <= n_perr + (o_tgt_perr === 1'b1);
		n_wake <= n_wake + (o_wake === 1'b1);
	end

	task automatic check(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	function automatic cbsc_pkg::cbsc_cd_t cd_exp(input logic c1, c2);
		if (!c1 && !c2)
			return cbsc_pkg::CD_SEATED;
		return (c1 && c2) ? cbsc_pkg::CD_ABSENT : cbsc_pkg::CD_PARTIAL;
	endfunction : cd_exp

	// request held until a result pulse, then turnaround time
	task automatic host(input logic [3:0] cmd, input logic [31:0] a, d,
		input logic [3:0] be_n, input logic lk, output logic [2:0] r);
		int n;
		r = '0;
		i_cmd <= cmd;
		i_addr <= a;
		i_wdata <= d;
		i_be_n <= be_n;
		i_lock <= lk;
		i_req <= 1'b1;
		for (n = 0; n < 600 && r === 3'b000; n++) begin
			@(posedge i_clk);
			r = {o_abort, o_disc, o_done};
		end
		if (r === 3'b000) begin
			miscompares++;
			$display("mismatch host result expected pulse seen none");
			finish_test();
		end
		i_req <= 1'b0;
		i_lock <= 1'b0;
		repeat (40) @(posedge i_clk);
	endtask : host

	initial begin
		logic [2:0]  r;
		logic [31:0] a, d, q, v;
		logic [3:0]  be, nbe, cmd;
		logic        ok;
		int          k, wk, w0, p0;
		void'($urandom(94));
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (20) @(posedge i_clk);
		// host cycles to the card: random lanes, waits, stop, lock, abort
		for (k = 0; k < 11; k++) begin
			a = 32'h8000_0000 | ($urandom() & 32'h0FFF_FFFC);
			d = $urandom();
			be = $urandom();
			cmd = (k % 2 == 1 || k > 7) ? 4'h7 : 4'h6;
			c_wait <= (k < 2) ? 2'd0 : $urandom_range(0, 3);
			c_rdata <= d;
			c_stop <= (k == 8);
			if (k == 10)
				a = 32'h4000_0000;
			host(cmd, a, d, be, k == 9, r);
			check("host result", r, k == 10 ? 3'b100 :
				k == 8 ? 3'b011 : 3'b001);
			if (k < 10) begin
				check("card addr", i_cbsc_card_model.got_addr, a);
				check("card cmd", i_cbsc_card_model.got_cmd, cmd);
				check("card lanes", i_cbsc_card_model.got_be, be);
				check("last phase", i_cbsc_card_model.got_frame, 1'b1);
				check("addr par", i_cbsc_card_model.par_seen, ^{a, cmd});
				check("lock", i_cbsc_card_model.got_lock, k != 9);
				if (cmd[0])
					check("card data", i_cbsc_card_model.got_data, d);
				else
					check("read data", o_rdata, d);
			end
		end
		c_stop <= 1'b0;
		$display("test host cycles done");
		// card cycles: clean write, bad parity, special, read, burst
		for (k = 0; k < 5; k++) begin
			a = $urandom() & 32'h0000_0FFC;
			d = $urandom();
			be = $urandom();
			nbe = ~be;
			cmd = k == 3 ? 4'h6 : k == 2 ? 4'h1 : 4'h7;
			i_tgt_rdata <= d;
			w0 = n_wr;
			p0 = n_perr;
			i_cbsc_card_model.card_xfer(cmd, a, d, be, k == 1 || k == 2,
				k == 4, q, ok);
			repeat (60) @(posedge i_clk);
			check("perr pulses", n_perr - p0, k == 1);
			check("grant off", gnt_n, 1'b1);
			check("tgt stop", i_cbsc_card_model.got_stop, k == 4);
			if (k != 2)
				check("claim", ok, 1'b1);
			if (k < 2 || k == 4) begin
				check("tgt writes", n_wr - w0, 1);
				check("tgt addr", o_tgt_addr, a);
				check("tgt data", o_tgt_wdata, d);
				check("tgt lanes", o_tgt_be, nbe);
			end
			if (k == 1)
				check("perr delay", i_cbsc_card_model.perr_cyc
					- i_cbsc_card_model.done_cyc, 2);
			if (k == 3)
				check("card read", q, d);
		end
		$display("test card cycles done");
		// sideband pins at random; error line may stay low several clocks
		wk = 0;
		w0 = n_wake;
		for (k = 0; k < 12; k++) begin
			v = $urandom();
			wk += (v[4] != i_cstschg);
			{i_cint_n, i_caudio, i_audio_en, i_cserr_n, i_cstschg} <= v[4:0];
			{i_ccd1_n, i_ccd2_n, i_cvs1, i_cvs2} <= v[8:5];
			repeat (10) @(posedge i_clk);
			check("irq", o_irq, !i_cint_n);
			check("speaker", o_speaker_out, i_audio_en & i_caudio);
			check("serr", o_serr_n, i_cserr_n);
			check("detect", o_cd_state, cd_exp(i_ccd1_n, i_ccd2_n));
			check("vsense", o_vsense, {i_cvs2, i_cvs1});
		end
		check("wake pulses", n_wake - w0, wk);
		$display("test sideband done");
		finish_test();
	end
endmodule : cbsc_top_tb
